//--- core/lou_consts.svh
`ifndef LOU_CONSTS_SVH
`define LOU_CONSTS_SVH

// Register byte offsets
`define LOU_OFS_ACC 8'h00
`define LOU_OFS_FLAGS 8'h04
`define LOU_OFS_OPND 8'h08
`define LOU_OFS_ADDR 8'h0C
`define LOU_OFS_CMD 8'h10
`define LOU_OFS_STATUS 8'h14
`define LOU_OFS_RESULT 8'h18

// Operation codes
`define LOU_OP_AND 3'h0
`define LOU_OP_OR 3'h1
`define LOU_OP_XOR 3'h2
`define LOU_OP_NOT 3'h3
`define LOU_OP_NEG 3'h4

// Operand forms
`define LOU_FORM_A_IMM 3'h0
`define LOU_FORM_A_MEM 3'h1
`define LOU_FORM_MEM_A 3'h2
`define LOU_FORM_IO_A 3'h3
`define LOU_FORM_ACC 3'h4
`define LOU_FORM_MEM 3'h5

// Command fields
`define LOU_CMD_OP_HI 2
`define LOU_CMD_OP_LO 0
`define LOU_CMD_FORM_HI 6
`define LOU_CMD_FORM_LO 4

// Flag and status bits
`define LOU_FLAG_Z 0
`define LOU_FLAG_C 1
`define LOU_FLAG_AC 2
`define LOU_FLAG_OV 3
`define LOU_STAT_BUSY 0
`define LOU_STAT_BAD 1

// Reset values and constants
`define LOU_BYTE_ZERO 8'h00
`define LOU_BYTE_ONE 8'h01
`define LOU_WORD_ZERO 32'h0000_0000
`define LOU_OP_RST 3'h0
`define LOU_FORM_RST 3'h0

`endif

//--- core/lou_pkg.sv
package lou_pkg;

    typedef logic [7:0] lou_byte_t;
    typedef logic [2:0] lou_code_t;

    typedef enum logic [1:0] {
        LOU_S_IDLE,
        LOU_S_WAIT,
        LOU_S_EXEC,
        LOU_S_WR
    } lou_state_e;

endpackage

//--- core/lou_logic_alu.sv
`timescale 1ns/100ps
`include "lou_consts.svh"

module lou_logic_alu
    import lou_pkg::*;
(
    // Operation select
    input wire lou_code_t op,
    // Operands; unary forms act on b
    input wire lou_byte_t a,
    input wire lou_byte_t b,
    // Result
    output lou_byte_t result,
    output logic zero
);

    always_comb begin
        case (op)
            `LOU_OP_AND: result = a & b;
            `LOU_OP_OR: result = a | b;
            `LOU_OP_XOR: result = a ^ b;
            `LOU_OP_NOT: result = ~b;
            `LOU_OP_NEG: result = lou_byte_t'(~b + `LOU_BYTE_ONE);
            default: result = `LOU_BYTE_ZERO;
        endcase
        zero = (result == `LOU_BYTE_ZERO);
    end

endmodule

//--- core/lou_top.sv
// Overview of operation
// - AND accumulator with immediate or memory byte into accumulator or memory.
// - OR accumulator with immediate or memory byte into accumulator or memory.
// - XOR accumulator with immediate or memory byte into accumulator or memory.
// - XOR accumulator into an I/O register, writing it back; no flags change.
// - Complement accumulator or memory byte, storing it in place.
// - Negate accumulator or memory byte: inverted plus one, modulo 256.
// - Zero flag follows result except I/O XOR; carry, aux, overflow untouched.
// - Memory forms read, combine, write same address; accumulator unchanged.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
`include "lou_consts.svh"

module lou_top
    import lou_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Data memory and I/O register file
    output logic [7:0] dm_addr,
    output logic dm_io_sel,
    output logic dm_rd,
    output logic dm_wr,
    output logic [7:0] dm_wdata,
    input wire logic [7:0] dm_rdata,
    input wire logic dm_rvalid,
    // Flag and state view
    output logic zero_flag,
    output logic carry_flag,
    output logic aux_carry_flag,
    output logic overflow_flag,
    output logic busy
);

    function automatic logic cmd_legal(input lou_code_t op, input lou_code_t form);
        logic ok;
        ok = 1'b0;
        case (op)
            `LOU_OP_AND, `LOU_OP_OR: begin
                ok = (form == `LOU_FORM_A_IMM) || (form == `LOU_FORM_A_MEM)
                    || (form == `LOU_FORM_MEM_A);
            end
            `LOU_OP_XOR: begin
                ok = (form == `LOU_FORM_A_IMM) || (form == `LOU_FORM_A_MEM)
                    || (form == `LOU_FORM_MEM_A) || (form == `LOU_FORM_IO_A);
            end
            `LOU_OP_NOT, `LOU_OP_NEG: begin
                ok = (form == `LOU_FORM_ACC) || (form == `LOU_FORM_MEM);
            end
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    function automatic logic form_reads(input lou_code_t form);
        return (form == `LOU_FORM_A_MEM) || (form == `LOU_FORM_MEM_A)
            || (form == `LOU_FORM_IO_A) || (form == `LOU_FORM_MEM);
    endfunction

    function automatic logic form_writes(input lou_code_t form);
        return (form == `LOU_FORM_MEM_A) || (form == `LOU_FORM_IO_A)
            || (form == `LOU_FORM_MEM);
    endfunction

    function automatic logic [31:0] byte_word(input lou_byte_t b);
        return {24'h00_0000, b};
    endfunction

    // Bus handshake state
    logic ack_reg;
    logic ack_next;
    logic [31:0] readdata_reg;
    logic [31:0] readdata_next;
    logic bus_req;
    logic bus_take;
    logic wr_fire;

    // Architectural and sequencing state
    lou_state_e state_reg;
    lou_state_e state_next;
    lou_byte_t accumulator_reg;
    lou_byte_t accumulator_next;
    logic zero_flag_reg;
    logic zero_flag_next;
    logic carry_flag_reg;
    logic carry_flag_next;
    logic aux_carry_flag_reg;
    logic aux_carry_flag_next;
    logic overflow_flag_reg;
    logic overflow_flag_next;
    lou_byte_t imm_reg;
    lou_byte_t imm_next;
    lou_byte_t addr_reg;
    lou_byte_t addr_next;
    lou_code_t op_reg;
    lou_code_t op_next;
    lou_code_t form_reg;
    lou_code_t form_next;
    lou_byte_t opnd_reg;
    lou_byte_t opnd_next;
    lou_byte_t result_reg;
    lou_byte_t result_next;
    logic bad_cmd_reg;
    logic bad_cmd_next;
    logic dm_rd_reg;
    logic dm_rd_next;
    logic dm_wr_reg;
    logic dm_wr_next;
    logic dm_io_sel_reg;
    logic dm_io_sel_next;
    lou_byte_t dm_addr_reg;
    lou_byte_t dm_addr_next;
    lou_byte_t dm_wdata_reg;
    lou_byte_t dm_wdata_next;

    lou_byte_t alu_result;
    logic alu_zero;
    lou_code_t new_op;
    lou_code_t new_form;

    lou_logic_alu u_alu (
        .op(op_reg),
        .a(accumulator_reg),
        .b(opnd_reg),
        .result(alu_result),
        .zero(alu_zero)
    );

    assign busy = (state_reg != LOU_S_IDLE);
    assign bus_req = avs_read | avs_write;
    // Accesses wait out a running operation so software never races it
    assign bus_take = bus_req & ~ack_reg & ~busy;
    assign wr_fire = avs_write & ack_reg & avs_byteenable[0];
    assign avs_waitrequest = bus_req & ~ack_reg;
    assign avs_readdata = readdata_reg;
    assign new_op = avs_writedata[`LOU_CMD_OP_HI:`LOU_CMD_OP_LO];
    assign new_form = avs_writedata[`LOU_CMD_FORM_HI:`LOU_CMD_FORM_LO];

    assign dm_addr = dm_addr_reg;
    assign dm_io_sel = dm_io_sel_reg;
    assign dm_rd = dm_rd_reg;
    assign dm_wr = dm_wr_reg;
    assign dm_wdata = dm_wdata_reg;
    assign zero_flag = zero_flag_reg;
    assign carry_flag = carry_flag_reg;
    assign aux_carry_flag = aux_carry_flag_reg;
    assign overflow_flag = overflow_flag_reg;

    always_comb begin
        ack_next = bus_take;
        readdata_next = readdata_reg;
        if (bus_take && avs_read) begin
            case (avs_address)
                `LOU_OFS_ACC: readdata_next = byte_word(accumulator_reg);
                `LOU_OFS_FLAGS: begin
                    readdata_next = `LOU_WORD_ZERO;
                    readdata_next[`LOU_FLAG_Z] = zero_flag_reg;
                    readdata_next[`LOU_FLAG_C] = carry_flag_reg;
                    readdata_next[`LOU_FLAG_AC] = aux_carry_flag_reg;
                    readdata_next[`LOU_FLAG_OV] = overflow_flag_reg;
                end
                `LOU_OFS_OPND: readdata_next = byte_word(imm_reg);
                `LOU_OFS_ADDR: readdata_next = byte_word(addr_reg);
                `LOU_OFS_CMD: begin
                    readdata_next = `LOU_WORD_ZERO;
                    readdata_next[`LOU_CMD_OP_HI:`LOU_CMD_OP_LO] = op_reg;
                    readdata_next[`LOU_CMD_FORM_HI:`LOU_CMD_FORM_LO] = form_reg;
                end
                `LOU_OFS_STATUS: begin
                    readdata_next = `LOU_WORD_ZERO;
                    readdata_next[`LOU_STAT_BUSY] = busy;
                    readdata_next[`LOU_STAT_BAD] = bad_cmd_reg;
                end
                `LOU_OFS_RESULT: readdata_next = byte_word(result_reg);
                default: readdata_next = `LOU_WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ack_reg <= 1'b0;
            readdata_reg <= `LOU_WORD_ZERO;
        end else begin
            ack_reg <= ack_next;
            readdata_reg <= readdata_next;
        end
    end

    always_comb begin
        state_next = state_reg;
        accumulator_next = accumulator_reg;
        zero_flag_next = zero_flag_reg;
        carry_flag_next = carry_flag_reg;
        aux_carry_flag_next = aux_carry_flag_reg;
        overflow_flag_next = overflow_flag_reg;
        imm_next = imm_reg;
        addr_next = addr_reg;
        op_next = op_reg;
        form_next = form_reg;
        opnd_next = opnd_reg;
        result_next = result_reg;
        bad_cmd_next = bad_cmd_reg;
        dm_rd_next = 1'b0;
        dm_wr_next = 1'b0;
        dm_io_sel_next = dm_io_sel_reg;
        dm_addr_next = dm_addr_reg;
        dm_wdata_next = dm_wdata_reg;
        case (state_reg)
            LOU_S_IDLE: begin
                if (wr_fire) begin
                    case (avs_address)
                        `LOU_OFS_ACC: accumulator_next = avs_writedata[7:0];
                        `LOU_OFS_FLAGS: begin
                            zero_flag_next = avs_writedata[`LOU_FLAG_Z];
                            carry_flag_next = avs_writedata[`LOU_FLAG_C];
                            aux_carry_flag_next = avs_writedata[`LOU_FLAG_AC];
                            overflow_flag_next = avs_writedata[`LOU_FLAG_OV];
                        end
                        `LOU_OFS_OPND: imm_next = avs_writedata[7:0];
                        `LOU_OFS_ADDR: addr_next = avs_writedata[7:0];
                        `LOU_OFS_STATUS: begin
                            if (avs_writedata[`LOU_STAT_BAD]) begin
                                bad_cmd_next = 1'b0;
                            end
                        end
                        `LOU_OFS_CMD: begin
                            op_next = new_op;
                            form_next = new_form;
                            if (!cmd_legal(new_op, new_form)) begin
                                // Illegal pairs run nothing; set beats any clear
                                bad_cmd_next = 1'b1;
                            end else if (form_reads(new_form)) begin
                                dm_addr_next = addr_reg;
                                dm_io_sel_next = (new_form == `LOU_FORM_IO_A);
                                dm_rd_next = 1'b1;
                                state_next = LOU_S_WAIT;
                            end else if (new_form == `LOU_FORM_ACC) begin
                                opnd_next = accumulator_reg;
                                state_next = LOU_S_EXEC;
                            end else begin
                                opnd_next = imm_reg;
                                state_next = LOU_S_EXEC;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            LOU_S_WAIT: begin
                if (dm_rvalid) begin
                    opnd_next = dm_rdata;
                    state_next = LOU_S_EXEC;
                end
            end
            LOU_S_EXEC: begin
                result_next = alu_result;
                if (form_reg != `LOU_FORM_IO_A) begin
                    zero_flag_next = alu_zero;
                end
                if (form_writes(form_reg)) begin
                    // Same address as the read, accumulator left alone
                    dm_wdata_next = alu_result;
                    dm_wr_next = 1'b1;
                    state_next = LOU_S_WR;
                end else begin
                    accumulator_next = alu_result;
                    state_next = LOU_S_IDLE;
                end
            end
            LOU_S_WR: begin
                state_next = LOU_S_IDLE;
            end
            default: state_next = LOU_S_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= LOU_S_IDLE;
            accumulator_reg <= `LOU_BYTE_ZERO;
            zero_flag_reg <= 1'b0;
            carry_flag_reg <= 1'b0;
            aux_carry_flag_reg <= 1'b0;
            overflow_flag_reg <= 1'b0;
            imm_reg <= `LOU_BYTE_ZERO;
            addr_reg <= `LOU_BYTE_ZERO;
            op_reg <= `LOU_OP_RST;
            form_reg <= `LOU_FORM_RST;
            opnd_reg <= `LOU_BYTE_ZERO;
            result_reg <= `LOU_BYTE_ZERO;
            bad_cmd_reg <= 1'b0;
            dm_rd_reg <= 1'b0;
            dm_wr_reg <= 1'b0;
            dm_io_sel_reg <= 1'b0;
            dm_addr_reg <= `LOU_BYTE_ZERO;
            dm_wdata_reg <= `LOU_BYTE_ZERO;
        end else begin
            state_reg <= state_next;
            accumulator_reg <= accumulator_next;
            zero_flag_reg <= zero_flag_next;
            carry_flag_reg <= carry_flag_next;
            aux_carry_flag_reg <= aux_carry_flag_next;
            overflow_flag_reg <= overflow_flag_next;
            imm_reg <= imm_next;
            addr_reg <= addr_next;
            op_reg <= op_next;
            form_reg <= form_next;
            opnd_reg <= opnd_next;
            result_reg <= result_next;
            bad_cmd_reg <= bad_cmd_next;
            dm_rd_reg <= dm_rd_next;
            dm_wr_reg <= dm_wr_next;
            dm_io_sel_reg <= dm_io_sel_next;
            dm_addr_reg <= dm_addr_next;
            dm_wdata_reg <= dm_wdata_next;
        end
    end

endmodule

//--- testbench/lou_top_asserts.sv
`timescale 1ns/100ps
`include "lou_consts.svh"
module lou_top_chk (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Bus
    input wire logic [7:0] avs_address,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    // Memory port
    input wire logic [7:0] dm_addr,
    input wire logic dm_io_sel,
    input wire logic dm_rd,
    input wire logic dm_wr,
    input wire logic [7:0] dm_wdata,
    input wire logic [7:0] dm_rdata,
    input wire logic dm_rvalid,
    // Flags and state
    input wire logic zero_flag,
    input wire logic carry_flag,
    input wire logic aux_carry_flag,
    input wire logic overflow_flag,
    input wire logic busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    logic cmd_go, flag_go, mem_form;
    logic [2:0] op_reg, op_next, form_reg, form_next;
    logic [7:0] addr_reg, addr_next, rdat_reg, rdat_next;
    assign cmd_go = avs_write && !avs_waitrequest && avs_byteenable[0]
        && avs_address == `LOU_OFS_CMD;
    assign flag_go = avs_write && !avs_waitrequest && avs_address == `LOU_OFS_FLAGS;
    assign mem_form = form_reg == `LOU_FORM_MEM_A || form_reg == `LOU_FORM_IO_A
        || form_reg == `LOU_FORM_MEM;
    // Operation context, since the checker cannot see the decoder
    always_comb begin
        op_next = op_reg;
        form_next = form_reg;
        addr_next = addr_reg;
        rdat_next = rdat_reg;
        if (cmd_go) begin
            op_next = avs_writedata[2:0];
            form_next = avs_writedata[6:4];
        end
        if (dm_rd) addr_next = dm_addr;
        if (dm_rvalid) rdat_next = dm_rdata;
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            op_reg <= 3'h0;
            form_reg <= 3'h0;
            addr_reg <= 8'h00;
            rdat_reg <= 8'h00;
        end else begin
            op_reg <= op_next;
            form_reg <= form_next;
            addr_reg <= addr_next;
            rdat_reg <= rdat_next;
        end
    end
    a_carry_kept: assert property (!flag_go |=> $stable(carry_flag))
        else $error("carry flag changed by an operation");
    a_aux_kept: assert property (!flag_go |=> $stable(aux_carry_flag))
        else $error("aux carry flag changed by an operation");
    a_ovf_kept: assert property (!flag_go |=> $stable(overflow_flag))
        else $error("overflow flag changed by an operation");
    a_io_zero_kept: assert property (busy && form_reg == `LOU_FORM_IO_A |=> $stable(zero_flag))
        else $error("zero flag changed by io xor");
    a_zero_match: assert property (dm_wr && form_reg != `LOU_FORM_IO_A |-> zero_flag == (dm_wdata == 8'h00))
        else $error("zero flag does not match stored result");
    a_mem_writeback: assert property (dm_rvalid && busy && mem_form |-> ##2 dm_wr)
        else $error("no write back two cycles after read data");
    a_acc_no_write: assert property (dm_rvalid && busy && form_reg == `LOU_FORM_A_MEM |-> ##1 (!dm_wr) [*3])
        else $error("memory written by accumulator form");
    a_same_addr: assert property (dm_wr |-> dm_addr == addr_reg && dm_io_sel == (form_reg == `LOU_FORM_IO_A))
        else $error("write back to another place");
    a_not_data: assert property (dm_wr && op_reg == `LOU_OP_NOT |-> dm_wdata == ~rdat_reg)
        else $error("stored complement wrong");
    a_neg_data: assert property (dm_wr && op_reg == `LOU_OP_NEG |-> dm_wdata == 8'h00 - rdat_reg)
        else $error("stored negation wrong");
    c_io_write: cover property (dm_wr && dm_io_sel);
    c_mem_read: cover property (dm_rvalid && busy);
    c_flag_write: cover property (flag_go);
endmodule

//--- testbench/lou_mem_model.sv
`timescale 1ns/100ps
module lou_mem_model (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Memory port
    input wire logic [7:0] dm_addr,
    input wire logic dm_io_sel,
    input wire logic dm_rd,
    input wire logic dm_wr,
    input wire logic [7:0] dm_wdata,
    output logic [7:0] dm_rdata,
    output logic dm_rvalid
);
    logic [7:0] mem [256];
    logic [7:0] io [256];
    int lat = 0;
    int cnt;
    logic pend;
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pend <= 1'b0;
            cnt <= 0;
            dm_rvalid <= 1'b0;
            dm_rdata <= 8'h00;
        end else begin
            dm_rvalid <= 1'b0;
            // Toggle outside valid so stale data never looks right
            dm_rdata <= ~dm_rdata;
            if (dm_rd) begin
                pend <= 1'b1;
                cnt <= lat;
            end else if (pend && cnt != 0) begin
                cnt <= cnt - 1;
            end else if (pend) begin
                pend <= 1'b0;
                dm_rvalid <= 1'b1;
                dm_rdata <= dm_io_sel ? io[dm_addr] : mem[dm_addr];
            end
            if (dm_wr && dm_io_sel) io[dm_addr] <= dm_wdata;
            else if (dm_wr) mem[dm_addr] <= dm_wdata;
        end
    end
endmodule

//--- testbench/test_logic_op_unit.sv
`timescale 1ns/100ps
`include "lou_consts.svh"
module test_logic_op_unit;
    logic clock, arst_n, avs_read, avs_write, avs_waitrequest, busy;
    logic dm_io_sel, dm_rd, dm_wr, dm_rvalid;
    logic zero_flag, carry_flag, aux_carry_flag, overflow_flag;
    logic [7:0] avs_address, dm_addr, dm_wdata, dm_rdata;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable;
    int n_errors = 0;
    int n_compared = 0;
    lou_top u_lou_top (.clock(clock), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .dm_addr(dm_addr), .dm_io_sel(dm_io_sel),
        .dm_rd(dm_rd), .dm_wr(dm_wr), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata),
        .dm_rvalid(dm_rvalid), .zero_flag(zero_flag), .carry_flag(carry_flag),
        .aux_carry_flag(aux_carry_flag), .overflow_flag(overflow_flag), .busy(busy));
    lou_mem_model u_lou_mem_model (.clock(clock), .arst_n(arst_n), .dm_addr(dm_addr),
        .dm_io_sel(dm_io_sel), .dm_rd(dm_rd), .dm_wr(dm_wr), .dm_wdata(dm_wdata),
        .dm_rdata(dm_rdata), .dm_rvalid(dm_rvalid));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task test_done;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Holds the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0 && n < 100) begin
            @(posedge clock);
            n++;
        end
        if (n >= 100) begin
            n_errors++;
            test_done;
        end
        // Read data stands at the edge that ends the wait
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask
    task automatic run_op(input logic [2:0] op, input logic [2:0] form, input logic [7:0] acc,
        input logic [7:0] b, input logic [3:0] fl);
        logic [7:0] x, r;
        logic md;
        x = (form == `LOU_FORM_ACC) ? acc : b;
        case (op)
            `LOU_OP_AND: r = acc & x;
            `LOU_OP_OR: r = acc | x;
            `LOU_OP_XOR: r = acc ^ x;
            `LOU_OP_NOT: r = ~x;
            default: r = 8'h00 - x;
        endcase
        md = form == `LOU_FORM_MEM_A || form == `LOU_FORM_IO_A || form == `LOU_FORM_MEM;
        u_lou_mem_model.mem[8'h5A] = b;
        u_lou_mem_model.io[8'h5A] = b;
        bus(1'b1, `LOU_OFS_ACC, acc);
        bus(1'b1, `LOU_OFS_FLAGS, {4'h0, fl});
        bus(1'b1, `LOU_OFS_OPND, b);
        bus(1'b1, `LOU_OFS_ADDR, 8'h5A);
        bus(1'b1, `LOU_OFS_CMD, {1'b0, form, 1'b0, op});
        bus(1'b0, `LOU_OFS_STATUS, 8'h00);
        bus(1'b0, `LOU_OFS_ACC, 8'h00);
        chk(rd, 32'(md ? acc : r));
        bus(1'b0, `LOU_OFS_RESULT, 8'h00);
        chk(rd, 32'(r));
        bus(1'b0, `LOU_OFS_FLAGS, 8'h00);
        chk(rd, 32'(form == `LOU_FORM_IO_A ? fl : {fl[3:1], r == 8'h00}));
        chk(32'(form == `LOU_FORM_IO_A ? u_lou_mem_model.io[8'h5A] : u_lou_mem_model.mem[8'h5A]),
            32'(md ? r : b));
    endtask
    // Pairs chosen so AND and XOR hit a zero result and OR and XOR hit an all-ones result
    task t_binary;
        logic [7:0] av [3] = '{8'h3C, 8'hA5, 8'hA5};
        logic [7:0] bv [3] = '{8'h0F, 8'h5A, 8'hA5};
        for (int f = 0; f < 3; f++) begin
            for (int o = 0; o < 3; o++) begin
                for (int i = 0; i < 3; i++) begin
                    u_lou_mem_model.lat = i * 2;
                    run_op(3'(o), 3'(f), av[i], bv[i], (i == 1) ? 4'h1 : 4'hE);
                end
            end
        end
        $display("binary operations done");
    endtask
    task t_unary;
        logic [7:0] v [3] = '{8'h00, 8'h80, 8'h38};
        for (int o = 3; o < 5; o++) begin
            for (int i = 0; i < 3; i++) begin
                u_lou_mem_model.lat = i;
                run_op(3'(o), `LOU_FORM_ACC, v[i], 8'h77, 4'hA);
                run_op(3'(o), `LOU_FORM_MEM, 8'h11, v[i], 4'h5);
            end
        end
        $display("unary operations done");
    endtask
    task t_io_xor;
        u_lou_mem_model.lat = 3;
        run_op(`LOU_OP_XOR, `LOU_FORM_IO_A, 8'h5A, 8'h5A, 4'hE);
        run_op(`LOU_OP_XOR, `LOU_FORM_IO_A, 8'h81, 8'h18, 4'h1);
        run_op(`LOU_OP_XOR, `LOU_FORM_IO_A, 8'hFF, 8'h00, 4'hF);
        $display("io xor done");
    endtask
    // Illegal pairs and masked writes must leave the datapath alone
    task t_bad;
        bus(1'b1, `LOU_OFS_ACC, 8'h3C);
        avs_byteenable <= 4'hE;
        bus(1'b1, `LOU_OFS_ACC, 8'hC3);
        avs_byteenable <= 4'hF;
        bus(1'b1, `LOU_OFS_CMD, {1'b0, `LOU_FORM_ACC, 1'b0, `LOU_OP_AND});
        bus(1'b0, `LOU_OFS_STATUS, 8'h00);
        chk(rd, 32'h0000_0002);
        bus(1'b0, `LOU_OFS_ACC, 8'h00);
        chk(rd, 32'h0000_003C);
        bus(1'b1, `LOU_OFS_STATUS, 8'h02);
        bus(1'b0, `LOU_OFS_STATUS, 8'h00);
        chk(rd, 32'h0000_0000);
        bus(1'b0, `LOU_OFS_CMD, 8'h00);
        chk(rd, 32'h0000_0040);
        $display("illegal command done");
    endtask
    initial begin
        arst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 8'h00;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'hF;
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        t_binary;
        t_unary;
        t_io_xor;
        t_bad;
        test_done;
    end
endmodule
bind lou_top lou_top_chk u_lou_top_chk (.clock(clock), .arst_n(arst_n),
    .avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest), .dm_addr(dm_addr),
    .dm_io_sel(dm_io_sel), .dm_rd(dm_rd), .dm_wr(dm_wr), .dm_wdata(dm_wdata),
    .dm_rdata(dm_rdata), .dm_rvalid(dm_rvalid), .zero_flag(zero_flag),
    .carry_flag(carry_flag), .aux_carry_flag(aux_carry_flag),
    .overflow_flag(overflow_flag), .busy(busy));
